// ===== inc/pmx_pkg.sv
// Constants, types and helper functions for the pin function multiplexer
package pmx_pkg;

	localparam int NUM_PINS = 13;
	localparam int FSEL_BITS = 3;
	localparam int FSEL_STRIDE = 4;
	localparam int FSEL_PINS_PER_REG = 8;

	// Pin indices into the pad vectors
	localparam logic [3:0] MODE_SELECT_PIN_IDX = 4'h1;
	localparam logic [3:0] SERIAL_TX_PIN_IDX = 4'h4;
	localparam logic [3:0] SERIAL_RX_PIN_IDX = 4'h5;

	// Pins with pull-up during reset and enabled inputs after release
	localparam logic [12:0] PULLUP_PIN_MASK = 13'h0EF2;
	localparam logic [12:0] MODE_PIN_MASK = 13'h0002;
	localparam logic [12:0] SERIAL_PIN_MASK = 13'h0030;

	// Register byte addresses
	localparam logic [7:0] ADDR_FSEL0 = 8'h00;
	localparam logic [7:0] ADDR_FSEL1 = 8'h04;
	localparam logic [7:0] ADDR_ENABLE = 8'h08;
	localparam logic [7:0] ADDR_DIR = 8'h0C;
	localparam logic [7:0] ADDR_OUT = 8'h10;
	localparam logic [7:0] ADDR_IN = 8'h14;
	localparam logic [7:0] ADDR_PULLUP = 8'h18;
	localparam logic [7:0] ADDR_PULLDN = 8'h1C;
	localparam logic [7:0] ADDR_STATUS = 8'h20;
	localparam int STATUS_MODE_BIT = 0;
	localparam int STATUS_CONFLICT_LSB = 16;

	// Selector codes
	localparam logic [2:0] SEL_GPIO = 3'h0;
	localparam logic [2:0] SEL_ANALOG = 3'h5;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [0:0] {
		ST_RESET = 1'b0,
		ST_RUN = 1'b1
	} pmx_state_type;

	typedef enum logic [4:0] {
		FN_NONE = 5'h00,
		FN_WAKE_A = 5'h01,
		FN_WAKE_B = 5'h02,
		FN_PULSE_A = 5'h03,
		FN_PULSE_C = 5'h04,
		FN_PULSE_D = 5'h05,
		FN_FW_DOUT = 5'h06,
		FN_FW_DIN = 5'h07,
		FN_TX = 5'h08,
		FN_RX = 5'h09,
		FN_SCL = 5'h0A,
		FN_SDA = 5'h0B,
		FN_SELECT = 5'h0C,
		FN_SCLK = 5'h0D,
		FN_RTS = 5'h0E,
		FN_CTS = 5'h0F,
		FN_ANALOG_CHANNEL_ONE = 5'h10,
		FN_ANALOG_CHANNEL_TWO = 5'h11,
		FN_ANALOG_CHANNEL_FOUR = 5'h12
	} pmx_func_type;

	localparam int FN_COUNT = 19;

	// Function offered by a pin for a selector code; anything unlisted is plain GPIO
	function automatic pmx_func_type pmx_func_of(input logic [3:0] pin, input logic [2:0] sel);
		case ({pin, sel})
			{4'h0, 3'h1}: pmx_func_of = FN_WAKE_A;
			{4'h1, 3'h1}: pmx_func_of = FN_PULSE_A;
			{4'h2, 3'h1}: pmx_func_of = FN_PULSE_C;
			{4'h2, 3'h2}: pmx_func_of = FN_FW_DOUT;
			{4'h2, 3'h5}: pmx_func_of = FN_ANALOG_CHANNEL_ONE;
			{4'h3, 3'h1}: pmx_func_of = FN_PULSE_D;
			{4'h3, 3'h2}: pmx_func_of = FN_FW_DIN;
			{4'h3, 3'h5}: pmx_func_of = FN_ANALOG_CHANNEL_TWO;
			{4'h4, 3'h1}: pmx_func_of = FN_TX;
			{4'h4, 3'h2}: pmx_func_of = FN_FW_DOUT;
			{4'h5, 3'h1}: pmx_func_of = FN_RX;
			{4'h5, 3'h2}: pmx_func_of = FN_FW_DIN;
			{4'h6, 3'h1}: pmx_func_of = FN_SCL;
			{4'h6, 3'h3}: pmx_func_of = FN_SELECT;
			{4'h6, 3'h4}: pmx_func_of = FN_RTS;
			{4'h7, 3'h1}: pmx_func_of = FN_SDA;
			{4'h7, 3'h3}: pmx_func_of = FN_SCLK;
			{4'h7, 3'h4}: pmx_func_of = FN_CTS;
			{4'h8, 3'h5}: pmx_func_of = FN_ANALOG_CHANNEL_FOUR;
			{4'h9, 3'h1}: pmx_func_of = FN_SCL;
			{4'h9, 3'h2}: pmx_func_of = FN_FW_DOUT;
			{4'hA, 3'h1}: pmx_func_of = FN_SDA;
			{4'hA, 3'h2}: pmx_func_of = FN_FW_DIN;
			{4'hC, 3'h1}: pmx_func_of = FN_WAKE_B;
			default: pmx_func_of = FN_NONE;
		endcase
	endfunction

	// Byte-strobe merge of a write into a stored word
	function automatic logic [31:0] pmx_merge(input logic [31:0] old, input logic [31:0] data,
			input logic [3:0] strb);
		for (int b = 0; b < 4; b++) begin
			pmx_merge[b*8 +: 8] = strb[b] ? data[b*8 +: 8] : old[b*8 +: 8];
		end
	endfunction

endpackage

// ===== src/pmx_top.sv
// Pin function multiplexer with reset pad states and an AXI4-Lite register slave
`timescale 1ns/1ps
module pmx_top
	import pmx_pkg::*;
(
	// Clock and resets
	input wire logic CLOCK,
	input wire logic RST,
	input wire logic RESET_N_INPUT,
	// AXI4-Lite slave
	input wire logic [7:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [7:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	// General pin pads
	input wire logic [12:0] PIN_IN,
	output logic [12:0] PIN_OUT,
	output logic [12:0] PIN_OE_N,
	output logic [12:0] PIN_INPUT_EN,
	output logic [12:0] PIN_PULL_UP,
	output logic [12:0] PIN_PULL_DOWN,
	output logic [12:0] PIN_ANALOG_EN,
	// Debug pads
	input wire logic DEBUG_DATA_IN,
	output logic DEBUG_DATA_OUT,
	output logic DEBUG_DATA_OE_N,
	output logic DEBUG_DATA_PULL_DOWN,
	input wire logic DEBUG_CLOCK_PIN,
	output logic DEBUG_CLOCK_PULL_DOWN,
	// Debug core side
	input wire logic CORE_DEBUG_DATA_OUT,
	input wire logic CORE_DEBUG_DATA_OE,
	output logic CORE_DEBUG_DATA_IN,
	output logic CORE_DEBUG_CLOCK,
	// Peripheral side
	output logic WAKE_INPUT_A,
	output logic WAKE_INPUT_B,
	input wire logic PULSE_OUT_A,
	input wire logic PULSE_OUT_C,
	input wire logic PULSE_OUT_D,
	input wire logic SERIAL_TX_OUT,
	output logic SERIAL_RX_IN,
	input wire logic SERIAL_RTS_N_OUT,
	output logic SERIAL_CTS_N_IN,
	input wire logic TWO_WIRE_SCL,
	input wire logic TWO_WIRE_SDA_OUT,
	output logic TWO_WIRE_SDA_IN,
	input wire logic FOUR_WIRE_DOUT,
	output logic FOUR_WIRE_DIN,
	input wire logic FOUR_WIRE_SELECT,
	input wire logic FOUR_WIRE_SCLK,
	output logic ANALOG_CHANNEL_ONE_EN,
	output logic ANALOG_CHANNEL_TWO_EN,
	output logic ANALOG_CHANNEL_FOUR_EN,
	// Mode
	output logic HOST_LINK_MODE
);

	logic rst_all;
	pmx_state_type state, next_state;
	logic host_mode, next_host_mode;
	logic [12:0][2:0] fsel, next_fsel;
	logic [12:0] pin_enable, next_pin_enable;
	logic [12:0] pin_dir, next_pin_dir;
	logic [12:0] pin_out_reg, next_pin_out_reg;
	logic [12:0] pull_up, next_pull_up;
	logic [12:0] pull_dn, next_pull_dn;
	logic [12:0] gpio_in, next_gpio_in;
	logic aw_pend, next_aw_pend, w_pend, next_w_pend;
	logic [7:0] aw_addr, next_aw_addr;
	logic [31:0] w_data, next_w_data;
	logic [3:0] w_strb, next_w_strb;
	logic bvalid, next_bvalid, rvalid, next_rvalid;
	logic [1:0] bresp, next_bresp, rresp, next_rresp;
	logic [31:0] rdata, next_rdata;
	logic [31:0] fsel0_word, fsel1_word, rd_word;
	logic rd_hit;
	logic [12:0] conflict;
	pmx_func_type eff_func [NUM_PINS];
	logic host_now;

	// The external active-low reset acts like the local reset
	assign rst_all = RST | ~RESET_N_INPUT;

	// Mode pin is pulled up in reset, so an open pin selects standalone mode
	assign host_now = ~PIN_IN[MODE_SELECT_PIN_IDX];

	assign S_AXI_AWREADY = (state == ST_RUN) & ~aw_pend & ~bvalid;
	assign S_AXI_WREADY = (state == ST_RUN) & ~w_pend & ~bvalid;
	assign S_AXI_ARREADY = (state == ST_RUN) & ~rvalid;
	assign S_AXI_BVALID = bvalid;
	assign S_AXI_BRESP = bresp;
	assign S_AXI_RVALID = rvalid;
	assign S_AXI_RRESP = rresp;
	assign S_AXI_RDATA = rdata;
	assign HOST_LINK_MODE = host_mode;

	////////////////////////////////////////////////////////////////////////////
	// Function resolution

	always_comb begin
		logic [FN_COUNT-1:0] used;
		pmx_func_type f;
		f = FN_NONE;
		used = '0;
		conflict = '0;
		for (int i = 0; i < NUM_PINS; i++) begin
			f = pmx_func_of(4'(i), fsel[i]);
			if (host_mode && 4'(i) == SERIAL_TX_PIN_IDX) begin
				f = FN_TX;
			end else if (host_mode && 4'(i) == SERIAL_RX_PIN_IDX) begin
				f = FN_RX;
			end
			// Lowest pin index wins; a later request for a taken function falls back to GPIO
			if (f != FN_NONE && used[f]) begin
				conflict[i] = 1'b1;
				f = FN_NONE;
			end else if (f != FN_NONE) begin
				used[f] = 1'b1;
			end
			eff_func[i] = f;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Register read mux

	always_comb begin
		fsel0_word = '0;
		fsel1_word = '0;
		for (int i = 0; i < NUM_PINS; i++) begin
			if (i < FSEL_PINS_PER_REG) begin
				fsel0_word[i*FSEL_STRIDE +: FSEL_BITS] = fsel[i];
			end else begin
				fsel1_word[(i-FSEL_PINS_PER_REG)*FSEL_STRIDE +: FSEL_BITS] = fsel[i];
			end
		end
		rd_hit = 1'b1;
		rd_word = '0;
		if (S_AXI_ARADDR == ADDR_FSEL0) begin
			rd_word = fsel0_word;
		end else if (S_AXI_ARADDR == ADDR_FSEL1) begin
			rd_word = fsel1_word;
		end else if (S_AXI_ARADDR == ADDR_ENABLE) begin
			rd_word = {19'h00000, pin_enable};
		end else if (S_AXI_ARADDR == ADDR_DIR) begin
			rd_word = {19'h00000, pin_dir};
		end else if (S_AXI_ARADDR == ADDR_OUT) begin
			rd_word = {19'h00000, pin_out_reg};
		end else if (S_AXI_ARADDR == ADDR_IN) begin
			rd_word = {19'h00000, gpio_in};
		end else if (S_AXI_ARADDR == ADDR_PULLUP) begin
			rd_word = {19'h00000, pull_up};
		end else if (S_AXI_ARADDR == ADDR_PULLDN) begin
			rd_word = {19'h00000, pull_dn};
		end else if (S_AXI_ARADDR == ADDR_STATUS) begin
			rd_word[STATUS_MODE_BIT] = host_mode;
			rd_word[STATUS_CONFLICT_LSB +: NUM_PINS] = conflict;
		end else begin
			rd_hit = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Control registers and bus handshake

	always_comb begin
		logic [31:0] wv;
		wv = '0;
		next_state = state;
		next_host_mode = host_mode;
		next_fsel = fsel;
		next_pin_enable = pin_enable;
		next_pin_dir = pin_dir;
		next_pin_out_reg = pin_out_reg;
		next_pull_up = pull_up;
		next_pull_dn = pull_dn;
		next_aw_pend = aw_pend | (S_AXI_AWVALID & S_AXI_AWREADY);
		next_aw_addr = (S_AXI_AWVALID & S_AXI_AWREADY) ? S_AXI_AWADDR : aw_addr;
		next_w_pend = w_pend | (S_AXI_WVALID & S_AXI_WREADY);
		next_w_data = (S_AXI_WVALID & S_AXI_WREADY) ? S_AXI_WDATA : w_data;
		next_w_strb = (S_AXI_WVALID & S_AXI_WREADY) ? S_AXI_WSTRB : w_strb;
		next_bvalid = bvalid & ~S_AXI_BREADY;
		next_bresp = bresp;
		next_rvalid = rvalid & ~S_AXI_RREADY;
		next_rresp = rresp;
		next_rdata = rdata;
		case (state)
			ST_RESET: begin
				// First cycle after release: latch the mode and set the post-release pad defaults
				next_state = ST_RUN;
				next_host_mode = host_now;
				next_pin_enable = PULLUP_PIN_MASK;
				next_pull_up = PULLUP_PIN_MASK;
				next_pull_dn = '0;
				if (host_now) begin
					next_pull_up = PULLUP_PIN_MASK & ~MODE_PIN_MASK & ~SERIAL_PIN_MASK;
					next_pull_dn = MODE_PIN_MASK;
				end
			end
			ST_RUN: begin
				if (aw_pend && w_pend && !bvalid) begin
					// Firmware may retune the general pads after start-up; in host mode the serial pins keep TX/RX with pulls off
					next_aw_pend = 1'b0;
					next_w_pend = 1'b0;
					next_bvalid = 1'b1;
					next_bresp = RESP_OKAY;
					if (aw_addr == ADDR_FSEL0) begin
						wv = pmx_merge(fsel0_word, w_data, w_strb);
						for (int i = 0; i < FSEL_PINS_PER_REG; i++) begin
							next_fsel[i] = wv[i*FSEL_STRIDE +: FSEL_BITS];
						end
					end else if (aw_addr == ADDR_FSEL1) begin
						wv = pmx_merge(fsel1_word, w_data, w_strb);
						for (int i = FSEL_PINS_PER_REG; i < NUM_PINS; i++) begin
							next_fsel[i] = wv[(i-FSEL_PINS_PER_REG)*FSEL_STRIDE +: FSEL_BITS];
						end
					end else if (aw_addr == ADDR_ENABLE) begin
						wv = pmx_merge({19'h00000, pin_enable}, w_data, w_strb);
						next_pin_enable = wv[12:0];
					end else if (aw_addr == ADDR_DIR) begin
						wv = pmx_merge({19'h00000, pin_dir}, w_data, w_strb);
						next_pin_dir = wv[12:0];
					end else if (aw_addr == ADDR_OUT) begin
						wv = pmx_merge({19'h00000, pin_out_reg}, w_data, w_strb);
						next_pin_out_reg = wv[12:0];
					end else if (aw_addr == ADDR_PULLUP) begin
						wv = pmx_merge({19'h00000, pull_up}, w_data, w_strb);
						next_pull_up = wv[12:0];
					end else if (aw_addr == ADDR_PULLDN) begin
						wv = pmx_merge({19'h00000, pull_dn}, w_data, w_strb);
						next_pull_dn = wv[12:0];
					end else if (aw_addr == ADDR_IN || aw_addr == ADDR_STATUS) begin
						next_bresp = RESP_OKAY;
					end else begin
						next_bresp = RESP_SLVERR;
					end
				end
				if (S_AXI_ARVALID && S_AXI_ARREADY) begin
					next_rvalid = 1'b1;
					next_rdata = rd_word;
					next_rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
				end
			end
			default: next_state = ST_RESET;
		endcase
	end

	always_ff @(posedge CLOCK) begin
		if (rst_all) begin
			state <= ST_RESET;
			host_mode <= 1'b0;
			fsel <= '0;
			pin_enable <= '0;
			pin_dir <= '0;
			pin_out_reg <= '0;
			pull_up <= PULLUP_PIN_MASK;
			pull_dn <= '0;
			aw_pend <= 1'b0;
			aw_addr <= '0;
			w_pend <= 1'b0;
			w_data <= '0;
			w_strb <= '0;
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
			rvalid <= 1'b0;
			rresp <= RESP_OKAY;
			rdata <= '0;
		end else begin
			state <= next_state;
			host_mode <= next_host_mode;
			fsel <= next_fsel;
			pin_enable <= next_pin_enable;
			pin_dir <= next_pin_dir;
			pin_out_reg <= next_pin_out_reg;
			pull_up <= next_pull_up;
			pull_dn <= next_pull_dn;
			aw_pend <= next_aw_pend;
			aw_addr <= next_aw_addr;
			w_pend <= next_w_pend;
			w_data <= next_w_data;
			w_strb <= next_w_strb;
			bvalid <= next_bvalid;
			bresp <= next_bresp;
			rvalid <= next_rvalid;
			rresp <= next_rresp;
			rdata <= next_rdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Pad and peripheral signals, registered so pads never see mux glitches

	logic [12:0] n_out, n_oe_n, n_ien, n_pu, n_pd, n_ana;
	logic n_wa, n_wb, n_rx, n_cts, n_sda, n_din, n_a1, n_a2, n_a4;

	always_comb begin
		logic en;
		en = 1'b0;
		n_out = '0;
		n_oe_n = '1;
		n_ien = '0;
		n_ana = '0;
		n_pu = pull_up;
		n_pd = pull_dn;
		n_wa = 1'b0;
		n_wb = 1'b0;
		n_rx = 1'b1;
		n_cts = 1'b1;
		n_sda = 1'b1;
		n_din = 1'b0;
		n_a1 = 1'b0;
		n_a2 = 1'b0;
		n_a4 = 1'b0;
		for (int i = 0; i < NUM_PINS; i++) begin
			en = (state == ST_RUN) & (pin_enable[i] | (host_mode & SERIAL_PIN_MASK[i]));
			if (en) begin
				n_ien[i] = 1'b1;
				case (eff_func[i])
					FN_PULSE_A: begin n_out[i] = PULSE_OUT_A; n_oe_n[i] = 1'b0; end
					FN_PULSE_C: begin n_out[i] = PULSE_OUT_C; n_oe_n[i] = 1'b0; end
					FN_PULSE_D: begin n_out[i] = PULSE_OUT_D; n_oe_n[i] = 1'b0; end
					FN_FW_DOUT: begin n_out[i] = FOUR_WIRE_DOUT; n_oe_n[i] = 1'b0; end
					FN_TX: begin n_out[i] = SERIAL_TX_OUT; n_oe_n[i] = 1'b0; end
					FN_SCL: begin n_out[i] = TWO_WIRE_SCL; n_oe_n[i] = 1'b0; end
					FN_SELECT: begin n_out[i] = FOUR_WIRE_SELECT; n_oe_n[i] = 1'b0; end
					FN_SCLK: begin n_out[i] = FOUR_WIRE_SCLK; n_oe_n[i] = 1'b0; end
					FN_RTS: begin n_out[i] = SERIAL_RTS_N_OUT; n_oe_n[i] = 1'b0; end
					// Open drain: only ever pulls low
					FN_SDA: begin n_oe_n[i] = TWO_WIRE_SDA_OUT; n_sda = PIN_IN[i]; end
					FN_WAKE_A: n_wa = PIN_IN[i];
					FN_WAKE_B: n_wb = PIN_IN[i];
					FN_RX: n_rx = PIN_IN[i];
					FN_CTS: n_cts = PIN_IN[i];
					FN_FW_DIN: n_din = PIN_IN[i];
					FN_ANALOG_CHANNEL_ONE: begin n_ien[i] = 1'b0; n_ana[i] = 1'b1; n_a1 = 1'b1; end
					FN_ANALOG_CHANNEL_TWO: begin n_ien[i] = 1'b0; n_ana[i] = 1'b1; n_a2 = 1'b1; end
					FN_ANALOG_CHANNEL_FOUR: begin n_ien[i] = 1'b0; n_ana[i] = 1'b1; n_a4 = 1'b1; end
					default: begin n_out[i] = pin_out_reg[i]; n_oe_n[i] = ~pin_dir[i]; end
				endcase
			end
		end
		if (host_mode) begin
			n_pu = n_pu & ~SERIAL_PIN_MASK;
			n_pd = n_pd & ~SERIAL_PIN_MASK;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (rst_all) begin
			// Everything disabled; only the pull-up group and the two debug pull-downs keep their resistors on
			PIN_OUT <= '0;
			PIN_OE_N <= '1;
			PIN_INPUT_EN <= '0;
			PIN_PULL_UP <= PULLUP_PIN_MASK;
			PIN_PULL_DOWN <= '0;
			PIN_ANALOG_EN <= '0;
			gpio_in <= '0;
			DEBUG_DATA_OUT <= 1'b0;
			DEBUG_DATA_OE_N <= 1'b1;
			DEBUG_DATA_PULL_DOWN <= 1'b1;
			DEBUG_CLOCK_PULL_DOWN <= 1'b1;
			CORE_DEBUG_DATA_IN <= 1'b0;
			CORE_DEBUG_CLOCK <= 1'b0;
			WAKE_INPUT_A <= 1'b0;
			WAKE_INPUT_B <= 1'b0;
			SERIAL_RX_IN <= 1'b1;
			SERIAL_CTS_N_IN <= 1'b1;
			TWO_WIRE_SDA_IN <= 1'b1;
			FOUR_WIRE_DIN <= 1'b0;
			ANALOG_CHANNEL_ONE_EN <= 1'b0;
			ANALOG_CHANNEL_TWO_EN <= 1'b0;
			ANALOG_CHANNEL_FOUR_EN <= 1'b0;
		end else begin
			PIN_OUT <= n_out;
			PIN_OE_N <= n_oe_n;
			PIN_INPUT_EN <= n_ien;
			PIN_PULL_UP <= n_pu;
			PIN_PULL_DOWN <= n_pd;
			PIN_ANALOG_EN <= n_ana;
			gpio_in <= PIN_IN & n_ien;
			// Clock keeps its pull-down so an open pin stays quiet
			DEBUG_DATA_OUT <= CORE_DEBUG_DATA_OUT;
			DEBUG_DATA_OE_N <= ~((state == ST_RUN) & CORE_DEBUG_DATA_OE);
			DEBUG_DATA_PULL_DOWN <= (state != ST_RUN);
			DEBUG_CLOCK_PULL_DOWN <= 1'b1;
			CORE_DEBUG_DATA_IN <= DEBUG_DATA_IN;
			CORE_DEBUG_CLOCK <= DEBUG_CLOCK_PIN & (state == ST_RUN);
			WAKE_INPUT_A <= n_wa;
			WAKE_INPUT_B <= n_wb;
			SERIAL_RX_IN <= n_rx;
			SERIAL_CTS_N_IN <= n_cts;
			TWO_WIRE_SDA_IN <= n_sda;
			FOUR_WIRE_DIN <= n_din;
			ANALOG_CHANNEL_ONE_EN <= n_a1;
			ANALOG_CHANNEL_TWO_EN <= n_a2;
			ANALOG_CHANNEL_FOUR_EN <= n_a4;
		end
	end

endmodule

// ===== tb/pmx_properties.sv
// Concurrent checks on the pin multiplexer ports
`timescale 1ns/1ps
module pmx_properties
	import pmx_pkg::*;
(
	// Clock and resets
	input wire logic CLOCK,
	input wire logic RST,
	input wire logic RESET_N_INPUT,
	// Bus handshakes
	input wire logic S_AXI_AWVALID,
	input wire logic S_AXI_AWREADY,
	input wire logic S_AXI_WVALID,
	input wire logic S_AXI_WREADY,
	input wire logic S_AXI_BVALID,
	// Pads
	input wire logic [12:0] PIN_IN,
	input wire logic [12:0] PIN_OUT,
	input wire logic [12:0] PIN_OE_N,
	input wire logic [12:0] PIN_INPUT_EN,
	input wire logic [12:0] PIN_PULL_UP,
	input wire logic [12:0] PIN_PULL_DOWN,
	input wire logic [12:0] PIN_ANALOG_EN,
	input wire logic DEBUG_DATA_OE_N,
	input wire logic DEBUG_DATA_PULL_DOWN,
	input wire logic DEBUG_CLOCK_PULL_DOWN,
	// Serial link and mode
	input wire logic SERIAL_TX_OUT,
	input wire logic SERIAL_RX_IN,
	input wire logic HOST_LINK_MODE
);
	logic in_rst;
	assign in_rst = RST | ~RESET_N_INPUT;
	default clocking cb @(posedge CLOCK);
	endclocking
	////////////////////////////////////////////////////////////////
	// Release with the mode pin at a level, then pads settle
	sequence s_release(lvl);
		$fell(in_rst) ##0 (PIN_IN[1] == lvl) ##1 !in_rst [*3];
	endsequence
	property p_reset_pads;
		$past(in_rst) |-> PIN_OE_N == 13'h1FFF && PIN_INPUT_EN == 13'h0 && PIN_ANALOG_EN == 13'h0
			&& PIN_PULL_UP == PULLUP_PIN_MASK && PIN_PULL_DOWN == 13'h0;
	endproperty
	a_reset_pads: assert property (p_reset_pads) else $error("pad state wrong in reset");
	property p_reset_debug;
		$past(in_rst) |-> DEBUG_DATA_OE_N && DEBUG_DATA_PULL_DOWN && DEBUG_CLOCK_PULL_DOWN && !HOST_LINK_MODE;
	endproperty
	a_reset_debug: assert property (p_reset_debug) else $error("debug pads wrong in reset");
	property p_debug_run;
		disable iff (in_rst) $fell(in_rst) ##1 !in_rst [*3] |-> !DEBUG_DATA_PULL_DOWN && DEBUG_CLOCK_PULL_DOWN;
	endproperty
	a_debug_run: assert property (p_debug_run) else $error("debug pulls wrong after release");
	property p_standalone;
		disable iff (in_rst) s_release(1'b1) |-> !HOST_LINK_MODE && PIN_PULL_UP == PULLUP_PIN_MASK
			&& PIN_PULL_DOWN == 13'h0 && PIN_INPUT_EN == PULLUP_PIN_MASK && PIN_OE_N == 13'h1FFF;
	endproperty
	a_standalone: assert property (p_standalone) else $error("standalone pads wrong");
	property p_host;
		disable iff (in_rst) s_release(1'b0) |-> HOST_LINK_MODE && PIN_PULL_DOWN[1] && !PIN_PULL_UP[1]
			&& ((PIN_PULL_UP | PIN_PULL_DOWN) & SERIAL_PIN_MASK) == 13'h0;
	endproperty
	a_host: assert property (p_host) else $error("host mode pads wrong");
	property p_tx_route;
		disable iff (in_rst) HOST_LINK_MODE ##1 HOST_LINK_MODE |-> !PIN_OE_N[4] && PIN_OUT[4] == $past(SERIAL_TX_OUT);
	endproperty
	a_tx_route: assert property (p_tx_route) else $error("transmit pin not routed");
	property p_rx_route;
		disable iff (in_rst) HOST_LINK_MODE ##1 HOST_LINK_MODE |-> SERIAL_RX_IN == $past(PIN_IN[5]);
	endproperty
	a_rx_route: assert property (p_rx_route) else $error("receive pin not routed");
	property p_write_answer;
		disable iff (in_rst) S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |-> ##2 S_AXI_BVALID;
	endproperty
	a_write_answer: assert property (p_write_answer) else $error("write response late");
endmodule
bind pmx_top pmx_properties u_props (.*);

// ===== tb/pmx_board_model.sv
// Board side of the pads: external drivers, pulls and floating lines
`timescale 1ns/1ps
module pmx_board_model
	import pmx_pkg::*;
(
	// Clock
	input wire logic clock,
	// Pad controls from the block
	input wire logic [12:0] pin_out,
	input wire logic [12:0] pin_oe_n,
	input wire logic [12:0] pin_pull_up,
	input wire logic [12:0] pin_pull_down,
	input wire logic debug_out,
	input wire logic debug_oe_n,
	input wire logic debug_pull_down,
	// Board drivers
	input wire logic [12:0] ext_en,
	input wire logic [12:0] ext_val,
	// Pad levels
	output logic [12:0] pin_in,
	output logic debug_in
);
	logic [12:0] wobble = 13'h0AAA;
	// Unpulled released lines toggle so a stale level never passes for a drive
	always_ff @(posedge clock) begin
		wobble <= ~wobble;
	end
	always_comb begin
		for (int i = 0; i < NUM_PINS; i++) begin
			pin_in[i] = !pin_oe_n[i] ? pin_out[i] : ext_en[i] ? ext_val[i] :
				pin_pull_up[i] ? 1'b1 : pin_pull_down[i] ? 1'b0 : wobble[i];
		end
		debug_in = !debug_oe_n ? debug_out : debug_pull_down ? 1'b0 : wobble[0];
	end
endmodule

// ===== tb/pmx_top_bench.sv
// Self-checking bench for the pin function multiplexer
`timescale 1ns/1ps
module pmx_top_bench;
	import pmx_pkg::*;
	logic CLOCK = 1'b0, RST = 1'b1, RESET_N_INPUT = 1'b0, CORE_DEBUG_DATA_OE = 1'b0;
	logic S_AXI_AWVALID = 0, S_AXI_WVALID = 0, S_AXI_BREADY = 0, S_AXI_ARVALID = 0, S_AXI_RREADY = 0;
	logic [7:0] S_AXI_AWADDR = 8'h00, S_AXI_ARADDR = 8'h00;
	logic [31:0] S_AXI_WDATA = 32'h0, S_AXI_RDATA;
	logic [3:0] S_AXI_WSTRB = 4'hF;
	logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
	logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
	logic [12:0] PIN_IN, PIN_OUT, PIN_OE_N, PIN_INPUT_EN, PIN_PULL_UP, PIN_PULL_DOWN, PIN_ANALOG_EN;
	logic DEBUG_DATA_IN, DEBUG_DATA_OUT, DEBUG_DATA_OE_N, DEBUG_DATA_PULL_DOWN, DEBUG_CLOCK_PIN, DEBUG_CLOCK_PULL_DOWN;
	logic CORE_DEBUG_DATA_OUT, CORE_DEBUG_DATA_IN, CORE_DEBUG_CLOCK, WAKE_INPUT_A, WAKE_INPUT_B, HOST_LINK_MODE;
	logic PULSE_OUT_A, PULSE_OUT_C, PULSE_OUT_D, SERIAL_TX_OUT, SERIAL_RX_IN, SERIAL_RTS_N_OUT, SERIAL_CTS_N_IN;
	logic TWO_WIRE_SCL, TWO_WIRE_SDA_OUT, TWO_WIRE_SDA_IN, FOUR_WIRE_DOUT, FOUR_WIRE_DIN, FOUR_WIRE_SELECT;
	logic FOUR_WIRE_SCLK, ANALOG_CHANNEL_ONE_EN, ANALOG_CHANNEL_TWO_EN, ANALOG_CHANNEL_FOUR_EN;
	logic [11:0] rnd = 12'h0, rnd_prev = 12'h0;
	logic [12:0] ext_en = 13'h0, ext_val = 13'h0, ext_prev = 13'h0;
	integer seed = 32'hc1fb;
	int err_total = 0, checks = 0, cycles = 0;
	always #12.5 CLOCK = ~CLOCK;
	pmx_top u_dut (.*);
	pmx_board_model u_board (.clock(CLOCK), .pin_out(PIN_OUT), .pin_oe_n(PIN_OE_N), .pin_pull_up(PIN_PULL_UP),
		.pin_pull_down(PIN_PULL_DOWN), .debug_out(DEBUG_DATA_OUT), .debug_oe_n(DEBUG_DATA_OE_N),
		.debug_pull_down(DEBUG_DATA_PULL_DOWN), .ext_en(ext_en), .ext_val(ext_val), .pin_in(PIN_IN),
		.debug_in(DEBUG_DATA_IN));
	assign {PULSE_OUT_A, PULSE_OUT_C, PULSE_OUT_D, SERIAL_TX_OUT, SERIAL_RTS_N_OUT, TWO_WIRE_SCL, TWO_WIRE_SDA_OUT,
		FOUR_WIRE_DOUT, FOUR_WIRE_SELECT, FOUR_WIRE_SCLK, DEBUG_CLOCK_PIN, CORE_DEBUG_DATA_OUT} = rnd;
	////////////////////////////////////////////////////////////////
	// Random peripheral and board traffic; the mode pin is only ever driven low
	always @(posedge CLOCK) begin
		rnd_prev <= rnd;
		rnd <= 12'($random(seed));
		ext_prev <= ext_val;
		ext_val <= 13'($random(seed)) & 13'h1FFD;
		cycles++;
		if (cycles == 5000) begin
			err_total++;
			report_and_stop;
		end
	end
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		checks++;
		if (got !== exp) begin
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
			err_total++;
		end
	endtask
	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic done, aw_hit, w_hit, b_hit;
		done = 1'b0;
		@(posedge CLOCK);
		S_AXI_AWADDR <= a;
		S_AXI_WDATA <= d;
		S_AXI_AWVALID <= 1'b1;
		S_AXI_WVALID <= 1'b1;
		S_AXI_BREADY <= 1'b1;
		// Handshakes are judged at the falling edge, where they stand settled until the next rising edge
		while (!done) begin
			@(negedge CLOCK);
			aw_hit = S_AXI_AWVALID && S_AXI_AWREADY;
			w_hit = S_AXI_WVALID && S_AXI_WREADY;
			b_hit = S_AXI_BVALID && S_AXI_BREADY;
			if (b_hit)
				chk(S_AXI_BRESP, er);
			@(posedge CLOCK);
			if (aw_hit)
				S_AXI_AWVALID <= 1'b0;
			if (w_hit)
				S_AXI_WVALID <= 1'b0;
			if (b_hit) begin
				S_AXI_BREADY <= 1'b0;
				done = 1'b1;
			end
		end
	endtask
	task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		logic ar_hit, r_hit;
		@(posedge CLOCK);
		S_AXI_ARADDR <= a;
		S_AXI_ARVALID <= 1'b1;
		S_AXI_RREADY <= 1'b1;
		do begin
			@(negedge CLOCK);
			ar_hit = S_AXI_ARVALID && S_AXI_ARREADY;
			r_hit = S_AXI_RVALID && S_AXI_RREADY;
			if (r_hit)
				chk({S_AXI_RRESP, S_AXI_RDATA}, {er, ed});
			@(posedge CLOCK);
			if (ar_hit)
				S_AXI_ARVALID <= 1'b0;
		end while (!r_hit);
		S_AXI_RREADY <= 1'b0;
	endtask
	task automatic do_reset(input logic use_rst, input logic host);
		@(posedge CLOCK);
		RST <= use_rst;
		RESET_N_INPUT <= 1'b0;
		ext_en[1] <= host;
		repeat (4) @(posedge CLOCK);
		@(negedge CLOCK);
		chk({PIN_OE_N, PIN_INPUT_EN, PIN_PULL_UP, PIN_PULL_DOWN}, {13'h1FFF, 13'h0, PULLUP_PIN_MASK, 13'h0});
		chk({DEBUG_DATA_OE_N, DEBUG_DATA_PULL_DOWN, DEBUG_CLOCK_PULL_DOWN}, 3'h7);
		@(posedge CLOCK);
		RST <= 1'b0;
		RESET_N_INPUT <= 1'b1;
		repeat (4) @(posedge CLOCK);
		@(negedge CLOCK);
		chk({HOST_LINK_MODE, DEBUG_DATA_PULL_DOWN, DEBUG_CLOCK_PULL_DOWN}, {host, 2'b01});
		chk({PIN_PULL_UP, PIN_PULL_DOWN}, {PULLUP_PIN_MASK & ~(host ? MODE_PIN_MASK | SERIAL_PIN_MASK : 13'h0),
			host ? MODE_PIN_MASK : 13'h0});
	endtask
	// Watch routed pads over several cycles with traffic running
	task automatic follow(input int mode);
		repeat (3) @(posedge CLOCK);
		repeat (8) begin
			@(negedge CLOCK);
			if (mode == 0)
				chk({PIN_OE_N[2], PIN_OUT[2], PIN_OE_N[4], FOUR_WIRE_DIN, WAKE_INPUT_A},
					{1'b0, rnd_prev[4], 1'b1, ext_prev[3], ext_prev[0]});
			else if (mode == 1)
				chk({PIN_OE_N[2], PIN_OUT[2], ANALOG_CHANNEL_ONE_EN, ANALOG_CHANNEL_TWO_EN, ANALOG_CHANNEL_FOUR_EN,
					PIN_ANALOG_EN}, {1'b0, rnd_prev[10], 3'b011, 13'h0108});
			else if (mode == 3)
				chk({PIN_OE_N[6], PIN_OUT[6], SERIAL_CTS_N_IN, WAKE_INPUT_B, PIN_OE_N[7], TWO_WIRE_SDA_IN},
					{1'b0, rnd_prev[7], ext_prev[7], ext_prev[12], 2'b11});
			else
				chk({PIN_OE_N[4], PIN_OUT[4], SERIAL_RX_IN, DEBUG_DATA_OE_N, DEBUG_DATA_OUT, CORE_DEBUG_CLOCK},
					{1'b0, rnd_prev[8], ext_prev[5], 1'b0, rnd_prev[0], rnd_prev[1]});
		end
	endtask
	task automatic report_and_stop;
		$display("checks=%0d err_total=%0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		do_reset(1'b1, 1'b0);
		axr(ADDR_STATUS, 32'h0, RESP_OKAY);
		axr(8'h24, 32'h0, RESP_SLVERR);
		axw(8'h40, 32'hFFFF_FFFF, RESP_SLVERR);
		axw(ADDR_ENABLE, 32'h0000_1FFF, RESP_OKAY);
		ext_en <= 13'h10A9;
		axw(ADDR_FSEL0, 32'h0022_2201, RESP_OKAY);
		axr(ADDR_FSEL0, 32'h0022_2201, RESP_OKAY);
		axr(ADDR_STATUS, 32'h0030_0000, RESP_OKAY);
		axw(ADDR_STATUS, 32'h0, RESP_OKAY);
		axr(ADDR_STATUS, 32'h0030_0000, RESP_OKAY);
		follow(0);
		axw(ADDR_FSEL0, 32'h4400_5100, RESP_OKAY);
		axw(ADDR_FSEL1, 32'h0001_0005, RESP_OKAY);
		follow(1);
		follow(3);
		axr(ADDR_STATUS, 32'h0, RESP_OKAY);
		do_reset(1'b0, 1'b1);
		axr(ADDR_STATUS, 32'h1, RESP_OKAY);
		CORE_DEBUG_DATA_OE <= 1'b1;
		follow(2);
		report_and_stop;
	end
endmodule
